// ---- hdl/ccr_attr_reg.sv ----
// One address attribute register with its multiplex bit held reserved.
// Assumes writes come from the bank's decoded Avalon-MM write strobe.
`timescale 1ns/1ps
`include "ccr_defs.svh"
module ccr_attr_reg (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             wr_en,
  input  wire ccr_pkg::ccr_word_t wr_data,
  output ccr_pkg::ccr_word_t    value_q,
  output logic                  mux_write_err
);
  ccr_pkg::ccr_word_t value_d;
  // Address multiplexing is unsupported, so the bit always reads as zero.
  assign value_d = wr_data & ~(ccr_pkg::ccr_word_t'(1) << `CCR_ADDR_MUX_BIT);
  assign mux_write_err = wr_en & wr_data[`CCR_ADDR_MUX_BIT];
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      value_q <= `CCR_AAR_RESET;
    end else if (wr_en) begin
      value_q <= value_d;
    end
  end
endmodule : ccr_attr_reg

// ---- hdl/ccr_core_config.sv ----
// Core configuration bank: PLL control, identification and address attribute registers.
// Assumes a single Avalon-MM master on clk; a PLL consumes the factor outputs.
`timescale 1ns/1ps
`include "ccr_defs.svh"
module ccr_core_config #(
  parameter logic [3:0]  REVISION   = 4'h0,
  parameter logic [11:0] DERIVATIVE = 12'h0_ABC // Arbitrary value that names no part.
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [12:0]      pll_mult_eff,
  output logic [4:0]       pll_prediv_eff,
  output logic             crystal_out_disable
);
  localparam int unsigned MF_WIDTH  = `CCR_MF_MSB - `CCR_MF_LSB + 1;
  localparam int unsigned PD_WIDTH  = `CCR_PD_MSB - `CCR_PD_LSB + 1;
  localparam logic [7:0]  ATTR_BASE = `CCR_OFS_ADDR_ATTR0;

  // The outputs and the lane decode rely on these widths, so any other register or field width stops the build.
  if (`CCR_REG_WIDTH != 24) begin : g_bad_width
    $error("Register width must be 24 bits.");
  end
  if (MF_WIDTH != 12) begin : g_bad_mf
    $error("Multiplier field must be 12 bits.");
  end
  if (PD_WIDTH != 4) begin : g_bad_pd
    $error("Predivider field must be 4 bits.");
  end
  if (`CCR_CRYSTAL_OUT_DISABLE_BIT >= `CCR_REG_WIDTH) begin : g_bad_crystal_out_disable
    $error("Crystal disable bit lies outside the register.");
  end
  if (`CCR_PLL_RESET != 24'h00_0000) begin : g_bad_reset
    $error("Reset must clear every control field.");
  end
  if (`CCR_AAR_COUNT != 4) begin : g_bad_count
    $error("Attribute register count must be four.");
  end
  if (ATTR_BASE[3:0] != 4'h0) begin : g_bad_base
    $error("Attribute block must start on a 16-byte boundary.");
  end

  ccr_pkg::ccr_state_e       state_q;
  ccr_pkg::ccr_state_e       state_d;
  ccr_pkg::ccr_word_t        pll_control_reg_q;
  ccr_pkg::ccr_word_t        pll_control_reg_d;
  ccr_pkg::ccr_word_t        pll_wr_mask;
  ccr_pkg::ccr_word_t        be_mask;
  ccr_pkg::ccr_word_t        wr_word;
  ccr_pkg::ccr_word_t        chip_ident_reg;
  ccr_pkg::ccr_word_t        attr_q [`CCR_AAR_COUNT];
  ccr_pkg::ccr_word_t        attr_sel;
  logic [`CCR_AAR_COUNT-1:0] attr_err;
  logic                      attr_full;
  logic                      mux_err_q;
  logic                      mux_err_d;
  logic [31:0]               rd_pll_word;
  logic [31:0]               rd_idr_word;
  logic [31:0]               rd_attr_word;
  logic [31:0]               rd_stat_word;
  logic [31:0]               rdata_d;
  logic                      req;
  logic                      take;
  logic                      launch;
  logic                      wr_take;
  logic                      rd_take;
  logic                      rd_launch;
  logic                      wait_d;
  logic                      hit_pll;
  logic                      hit_idr;
  logic                      hit_stat;
  logic                      hit_attr;
  logic                      pll_wr;
  logic                      stat_clr;
  logic [1:0]                attr_idx;
  logic [MF_WIDTH-1:0]       mult_field;
  logic [PD_WIDTH-1:0]       prediv_field;
  logic [12:0]               mult_eff_d;
  logic [4:0]                prediv_eff_d;
  logic                      xtal_dis_d;

  // One wait cycle: a request is launched on its first edge and taken on the next, which
  // leaves a whole cycle to register the read data.
  assign req       = (avs_read | avs_write) & ~sys_rst;
  assign take      = req & (state_q == ccr_pkg::CCR_RESP);
  assign launch    = req & (state_q == ccr_pkg::CCR_IDLE);
  assign wr_take   = take & avs_write;
  assign rd_take   = take & avs_read;
  assign rd_launch = launch & avs_read;
  assign wait_d    = ~launch;
  assign state_d   = launch ? ccr_pkg::CCR_RESP : ccr_pkg::CCR_IDLE;

  assign hit_pll  = avs_address == `CCR_OFS_PLL_CONTROL;
  assign hit_idr  = avs_address == `CCR_OFS_CHIP_IDENT;
  assign hit_stat = avs_address == `CCR_OFS_STATUS;
  assign hit_attr = (avs_address[7:4] == ATTR_BASE[7:4]) & (avs_address[1:0] == 2'b00);
  assign attr_idx = avs_address[3:2];
  assign pll_wr   = wr_take & hit_pll;
  assign stat_clr = rd_take & hit_stat;

  // Lane three carries no register bits, so its enable is ignored.
  assign be_mask     = {{8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_word     = avs_writedata[23:0];
  assign pll_wr_mask = be_mask & `CCR_PLL_WR_MASK;
  // A partial write would split an attribute register, so only a full write lands.
  assign attr_full   = &avs_byteenable[2:0];

  assign chip_ident_reg = {8'h00, REVISION, DERIVATIVE};

  // Reserved control bits are masked on write, so they always read back as zero.
  assign pll_control_reg_d = (pll_control_reg_q & ~pll_wr_mask) | (wr_word & pll_wr_mask);
  assign mult_field        = pll_control_reg_q[`CCR_MF_MSB:`CCR_MF_LSB];
  assign prediv_field      = pll_control_reg_q[`CCR_PD_MSB:`CCR_PD_LSB];
  assign mult_eff_d        = {1'b0, mult_field} + 13'h0001;
  assign prediv_eff_d      = {1'b0, prediv_field} + 5'h01;
  assign xtal_dis_d        = pll_control_reg_q[`CCR_CRYSTAL_OUT_DISABLE_BIT];

  assign attr_sel     = attr_q[attr_idx];
  assign rd_pll_word  = {8'h00, pll_control_reg_q};
  assign rd_idr_word  = {8'h00, chip_ident_reg};
  assign rd_attr_word = {8'h00, attr_sel};
  assign rd_stat_word = {31'h0000_0000, mux_err_q};
  assign rdata_d      = hit_pll  ? rd_pll_word  :
                        hit_idr  ? rd_idr_word  :
                        hit_attr ? rd_attr_word :
                        hit_stat ? rd_stat_word : `CCR_UNMAPPED_DATA;

  // A one written to the reserved multiplex bit is latched and a status read clears it.
  // The set wins when both fall in one cycle, so no such write goes unreported.
  assign mux_err_d = (|attr_err) | (mux_err_q & ~stat_clr);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ccr_pkg::CCR_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= wait_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_launch) begin
      avs_readdata <= rdata_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_control_reg_q <= `CCR_PLL_RESET;
    end else if (pll_wr) begin
      pll_control_reg_q <= pll_control_reg_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_mult_eff <= 13'h0001;
    end else begin
      pll_mult_eff <= mult_eff_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_prediv_eff <= 5'h01;
    end else begin
      pll_prediv_eff <= prediv_eff_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      crystal_out_disable <= 1'b0;
    end else begin
      crystal_out_disable <= xtal_dis_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mux_err_q <= 1'b0;
    end else begin
      mux_err_q <= mux_err_d;
    end
  end

  for (genvar i = 0; i < `CCR_AAR_COUNT; i++) begin : g_attr
    logic attr_hit;
    logic attr_wr;
    assign attr_hit = hit_attr & (attr_idx == 2'(i));
    assign attr_wr  = wr_take & attr_hit & attr_full;
    ccr_attr_reg u_attr (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .wr_en         (attr_wr),
      .wr_data       (wr_word),
      .value_q       (attr_q[i]),
      .mux_write_err (attr_err[i])
    );
  end
endmodule : ccr_core_config

// ---- hdl/ccr_defs.svh ----
// Register offsets, field positions, reset values and counts of the core configuration bank.
// Assumes inclusion by bare name from the package and the design files.
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH
`define CCR_OFS_PLL_CONTROL  8'h00
`define CCR_OFS_CHIP_IDENT   8'h04
`define CCR_OFS_ADDR_ATTR0   8'h10
`define CCR_OFS_STATUS       8'h20
`define CCR_REG_WIDTH        24
`define CCR_MF_LSB           0
`define CCR_MF_MSB           11
`define CCR_CRYSTAL_OUT_DISABLE_BIT         16
`define CCR_PD_LSB           20
`define CCR_PD_MSB           23
`define CCR_PLL_RESET        24'h00_0000
`define CCR_PLL_WR_MASK      24'hF1_0FFF
`define CCR_IDR_REV_LSB      12
`define CCR_IDR_REV_MSB      15
`define CCR_IDR_DER_MSB      11
`define CCR_ADDR_MUX_BIT     6
`define CCR_AAR_RESET        24'h00_0000
`define CCR_AAR_COUNT        4
`define CCR_UNMAPPED_DATA    32'hDEAD_BEEF
`endif

// ---- hdl/ccr_pkg.sv ----
// Types shared by the core configuration bank.
// Assumes ccr_defs.svh is on the include path.
`include "ccr_defs.svh"
package ccr_pkg;
  typedef logic [`CCR_REG_WIDTH-1:0] ccr_word_t;
  typedef enum logic [1:0] {
    CCR_IDLE,
    CCR_RESP
  } ccr_state_e;
endpackage : ccr_pkg

// ---- tb/ccr_core_config_assertions.sv ----
// Checker for the core configuration bank ports.
// Assumes one master that holds each request until waitrequest is low.
`timescale 1ns/1ps
module ccr_core_config_assertions #(
  parameter logic [3:0]  REVISION   = 4'h0,
  parameter logic [11:0] DERIVATIVE = 12'h0_ABC
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [12:0] pll_mult_eff,
  input wire logic [4:0]  pll_prediv_eff,
  input wire logic        crystal_out_disable
);
  wire ok = !avs_waitrequest;
  wire wa = ok && avs_write && avs_address == 8'h00;
  wire wp = wa && avs_byteenable[2:0] == 3'b111;
  wire rd = ok && avs_read;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Outputs are registered, so a taken write shows two edges later.
  wait_one_a: assert property ((avs_read | avs_write) & avs_waitrequest |=> ok)
    else $error("No answer.");
  wait_drop_a: assert property (ok |=> avs_waitrequest)
    else $error("Wait not raised again.");
  mult_set_a: assert property (wp |-> ##2 pll_mult_eff == $past(avs_writedata[11:0], 2) + 13'h1)
    else $error("Bad multiplier.");
  prediv_set_a: assert property (wp |-> ##2 pll_prediv_eff == $past(avs_writedata[23:20], 2) + 5'h1)
    else $error("Bad predivider.");
  xtal_set_a: assert property (wp |-> ##2 crystal_out_disable == $past(avs_writedata[16], 2))
    else $error("Bad crystal bit.");
  reset_out_a: assert property (disable iff (1'b0) sys_rst |=> pll_mult_eff == 13'h1
    && pll_prediv_eff == 5'h1 && !crystal_out_disable) else $error("Bad reset value.");
  id_read_a: assert property (rd && avs_address == 8'h04 |->
    avs_readdata == {16'h0000, REVISION, DERIVATIVE}) else $error("Bad identity.");
  attr_bit_a: assert property (rd && avs_address[7:4] == 4'h1 && avs_address[1:0] == 2'b00 |->
    avs_readdata[6] == 1'b0)
    else $error("Multiplex bit set.");
  pll_resv_a: assert property (rd && avs_address == 8'h00 |-> !(|(avs_readdata & 32'hFF0E_F000)))
    else $error("Reserved bit set.");
  mult_hold_a: assert property ($changed(pll_mult_eff) |-> $past(wa, 2))
    else $error("Multiplier moved.");
  cover property (wp);
  cover property (rd && avs_address == 8'h04);
  cover property (rd && avs_address == 8'h40);
  cover property (wa && avs_byteenable[2:0] != 3'b111);
endmodule : ccr_core_config_assertions
bind ccr_core_config ccr_core_config_assertions #(.REVISION(REVISION), .DERIVATIVE(DERIVATIVE))
  u_chk (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .avs_address         (avs_address),
    .avs_read            (avs_read),
    .avs_write           (avs_write),
    .avs_writedata       (avs_writedata),
    .avs_byteenable      (avs_byteenable),
    .avs_readdata        (avs_readdata),
    .avs_waitrequest     (avs_waitrequest),
    .pll_mult_eff        (pll_mult_eff),
    .pll_prediv_eff      (pll_prediv_eff),
    .crystal_out_disable (crystal_out_disable)
  );

// ---- tb/ccr_core_config_tb.sv ----
// Self-checking bench for the core configuration bank.
// Assumes the bank answers each Avalon-MM request after one wait cycle.
`timescale 1ns/1ps
module ccr_core_config_tb;
  typedef struct {logic [7:0] a; logic [31:0] d, e;} ccr_row_s;
  // Reset starts low so that its rise at time zero resets the design before the first edge.
  logic        clk = 1'b0, sys_rst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        avs_waitrequest, crystal_out_disable;
  logic [12:0] pll_mult_eff;
  logic [4:0]  pll_prediv_eff;
  int          err_total = 0, check_count = 0, cyc = 0;
  // Each row is written, then read back; the identity write must be ignored.
  ccr_row_s rows [9] = '{'{8'h00, 32'h00FF_FFFF, 32'h00F1_0FFF},
    '{8'h00, 32'h00A1_0123, 32'h00A1_0123}, '{8'h04, 32'h00FF_FFFF, 32'h0000_1ABC},
    '{8'h10, 32'h0012_3435, 32'h0012_3435}, '{8'h14, 32'h00AB_CD2E, 32'h00AB_CD2E},
    '{8'h1C, 32'h00FF_FFBF, 32'h00FF_FFBF}, '{8'h10, 32'h0000_0040, 32'h0000_0000},
    '{8'h20, 32'h0000_0000, 32'h0000_0001}, '{8'h40, 32'h1234_5678, 32'hDEAD_BEEF}};
  ccr_core_config #(.REVISION(4'h1)) DUT (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .avs_address         (avs_address),
    .avs_read            (avs_read),
    .avs_write           (avs_write),
    .avs_writedata       (avs_writedata),
    .avs_byteenable      (avs_byteenable),
    .avs_readdata        (avs_readdata),
    .avs_waitrequest     (avs_waitrequest),
    .pll_mult_eff        (pll_mult_eff),
    .pll_prediv_eff      (pll_prediv_eff),
    .crystal_out_disable (crystal_out_disable)
  );
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (++cyc == 3000) begin
    err_total++;
    close_out();
  end
  task chk(input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} <= {!w, w, a, d, b};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    {avs_read, avs_write} <= 2'b00;
  endtask : bus
  task outs(input logic [12:0] m, input logic [4:0] p, input logic x);
    chk({13'h0000, pll_mult_eff, pll_prediv_eff, crystal_out_disable}, {13'h0000, m, p, x});
  endtask : outs
  task rst;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    outs(13'h0001, 5'h01, 1'b0);
  endtask : rst
  task close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  initial begin
    rst();
    $display("reset test done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d, 4'hF);
      bus(1'b0, rows[i].a, 32'h0000_0000, 4'hF);
      chk(q, rows[i].e);
    end
    outs(13'h0124, 5'h0B, 1'b1);
    $display("row test done");
    bus(1'b1, 8'h14, 32'h0000_0000, 4'h3);
    bus(1'b0, 8'h14, 32'h0000_0000, 4'hF);
    chk(q, 32'h00AB_CD2E);
    bus(1'b0, 8'h20, 32'h0000_0000, 4'hF);
    chk(q, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h00F0_0FFF, 4'hF);
    repeat (2) @(posedge clk);
    outs(13'h1000, 5'h10, 1'b0);
    rst();
    bus(1'b0, 8'h00, 32'h0000_0000, 4'hF);
    chk(q, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h00FF_FFFF, 4'h1);
    bus(1'b0, 8'h00, 32'h0000_0000, 4'hF);
    chk(q, 32'h0000_00FF);
    outs(13'h0100, 5'h01, 1'b0);
    $display("edge test done");
    close_out();
  end
endmodule : ccr_core_config_tb
